// ---- common/sfpi_pkg.sv ----
// constants for the serial flash pin interface
package sfpi_pkg;
  localparam int unsigned CLK_MHZ = 10;
  localparam int unsigned SYNC_STAGES = 2;
  // array organisation
  localparam int unsigned PAGES = 4096;
  localparam int unsigned PAGE_W = 12;
  localparam int unsigned PAGE_BIG = 264;
  localparam int unsigned PAGE_BIN = 256;
  localparam int unsigned BYTE_W = 9;
  localparam int unsigned MEM_AW = 21;
  localparam int unsigned SECTORS = 16;
  localparam int unsigned SECT_W = 4;
  localparam int unsigned SEC_BYTES = 128;
  localparam int unsigned SEC_FACTORY = 64;
  // self-timed operation lengths
  localparam int unsigned PROG_TIME_US = 3000;
  localparam int unsigned ERASE_TIME_US = 4000;
  localparam int unsigned PROG_CYC = PROG_TIME_US * CLK_MHZ;
  localparam int unsigned ERASE_CYC = ERASE_TIME_US * CLK_MHZ;
  localparam int unsigned POR_CYC = 16;
  localparam int unsigned ADDR_BYTES = 3;
  // opcodes
  localparam logic [7:0] OP_BUF1_WRITE = 8'h84;
  localparam logic [7:0] OP_BUF2_WRITE = 8'h87;
  localparam logic [7:0] OP_BUF1_PROG = 8'h83;
  localparam logic [7:0] OP_BUF2_PROG = 8'h86;
  localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
  localparam logic [7:0] OP_ARRAY_READ = 8'h0b;
  localparam logic [7:0] OP_STATUS = 8'hd7;
  localparam logic [7:0] OP_SEC_READ = 8'h77;
  localparam logic [7:0] OP_SEC_PROG = 8'h9b;
  localparam logic [7:0] OP_PROT_ENABLE = 8'h3d;
  localparam logic [7:0] OP_PROT_DISABLE = 8'h3e;
  localparam logic [7:0] OP_PROT_WRITE = 8'h3f;
  localparam logic [7:0] OP_LOCKDOWN = 8'h30;
  localparam logic [7:0] OP_PAGE_BIN = 8'ha6;
  localparam logic [7:0] OP_PAGE_BIG = 8'ha7;
  // status byte fields
  localparam int unsigned ST_READY = 7;
  localparam int unsigned ST_WP = 2;
  localparam int unsigned ST_PROT = 1;
  localparam int unsigned ST_BIN = 0;
  localparam logic [7:0] ERASED = 8'hff;
  typedef enum {PH_IDLE, PH_OPCODE, PH_ADDR, PH_DUMMY, PH_WDATA, PH_RDATA, PH_DONE} sfpi_phase_t;
  typedef enum {OPS_IDLE, OPS_PROG, OPS_ERASE, OPS_OTP} sfpi_ops_t;
endpackage : sfpi_pkg

// ---- logic/sfpi_sync.sv ----
// two-flop synchronisers for the pin inputs
`timescale 1ns/1ps
`default_nettype none
module sfpi_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output var logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        meta_q[i] <= RST_VAL[i];
        q[i] <= RST_VAL[i];
      end else begin
        meta_q[i] <= d[i];
        q[i] <= meta_q[i];
      end
    end
  end
endmodule : sfpi_sync
`default_nettype wire

// ---- logic/sfpi_core.sv ----
// serial flash pin interface: framing, protection, reset and self-timed ops
// What this block does
// - operations start on select falling edge and end on its rising edge
// - deselected: standby, output undriven, serial input ignored
// - deselect during program or erase lets it finish before standby
// - input sampled on rising clock edge, output shifted on falling edge
// - works with clock idling low or high between frames
// - write-protect protects every sector, flagged or not, even without software protection
// - write-protect low refuses sector protection register changes
// - program or erase under write-protect is dropped; idle after deselect
// - protection enable and sector lockdown still work under write-protect
// - undriven write-protect counts as deasserted
// - reset pin low aborts work and holds idle until released
// - device makes its own power-on reset
// - program and erase timed internally, no host clocking needed
// - page size 256 or 264 bytes, 264 unless factory preset binary or set binary by the page-size command
// - main array holds 4096 pages of current page size
// - two page buffers; one fills while the other programs
// - 128-byte security register: 64 factory id, 64 user once
// - opcode byte first, then address bytes
// - all bytes shifted most significant bit first
`timescale 1ns/1ps
`default_nettype none
module sfpi_core #(
  parameter int unsigned PROG_CYCLES = sfpi_pkg::PROG_CYC,
  parameter int unsigned ERASE_CYCLES = sfpi_pkg::ERASE_CYC,
  parameter bit FACTORY_BIN = 1'b0,
  parameter logic [7:0] UID_SEED = 8'h5a // arbitrary id seed
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic wp_n,
  input wire logic reset_n,
  output var logic so,
  output var logic so_oe,
  output var logic standby,
  output var logic busy
);
  logic cs_n_s, sck_s, si_s, wp_n_s, rstp_n_s;
  logic cs_prev_q, sck_prev_q;
  logic [7:0] por_q, por_d;
  localparam sfpi_pkg::sfpi_phase_t PH_IDLE = sfpi_pkg::PH_IDLE, PH_OPCODE = sfpi_pkg::PH_OPCODE,
    PH_ADDR = sfpi_pkg::PH_ADDR, PH_DUMMY = sfpi_pkg::PH_DUMMY, PH_WDATA = sfpi_pkg::PH_WDATA,
    PH_RDATA = sfpi_pkg::PH_RDATA, PH_DONE = sfpi_pkg::PH_DONE;
  localparam sfpi_pkg::sfpi_ops_t OPS_IDLE = sfpi_pkg::OPS_IDLE, OPS_PROG = sfpi_pkg::OPS_PROG,
    OPS_ERASE = sfpi_pkg::OPS_ERASE, OPS_OTP = sfpi_pkg::OPS_OTP;
  sfpi_pkg::sfpi_phase_t phase_q, phase_d;
  sfpi_pkg::sfpi_ops_t opst_q, opst_d;
  logic [7:0] opc_q, opc_d, rx_q, rx_d, tx_q, tx_d;
  logic [2:0] bitc_q, bitc_d;
  logic [1:0] bytec_q, bytec_d;
  logic [23:0] addr_q, addr_d;
  logic [sfpi_pkg::PAGE_W-1:0] pg_q, pg_d, tgt_q, tgt_d;
  logic [sfpi_pkg::BYTE_W-1:0] by_q, by_d, idx_q, idx_d;
  logic cmd_done_q, cmd_done_d, src_q, src_d;
  logic so_q, so_d, oe_q, oe_d, stby_q, stby_d, busy_q, busy_d;
  logic [31:0] tmr_q, tmr_d;
  logic prot_en_q, prot_en_d, bin_q, bin_d, otp_used_q, otp_used_d;
  logic [sfpi_pkg::SECTORS-1:0] mask_q, mask_d, lock_q, lock_d;
  logic [7:0] bufm [2][sfpi_pkg::PAGE_BIG];
  logic [7:0] mainm [sfpi_pkg::PAGES * sfpi_pkg::PAGE_BIG];
  logic [7:0] secu [sfpi_pkg::SEC_FACTORY];
  logic bw_en, bw_sel, mw_en, sw_en;
  logic [sfpi_pkg::BYTE_W-1:0] bw_idx;
  logic [sfpi_pkg::MEM_AW-1:0] mw_idx;
  logic [5:0] sw_idx;
  logic [7:0] bw_data, mw_data, sw_data, byte_in, status, main_rd, sec_rd;
  logic sel, cs_fall, cs_rise, sck_rise, sck_fall, byte_done, int_clr, idle;
  logic [sfpi_pkg::BYTE_W-1:0] psize;
  logic [sfpi_pkg::SECT_W-1:0] tgt_sect;

  // pins reset to idle levels: select high, clock low, write-protect pulled high
  sfpi_sync #(.W(5), .RST_VAL(5'h13)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({cs_n, sck, si, wp_n, reset_n}),
    .q({cs_n_s, sck_s, si_s, wp_n_s, rstp_n_s})
  );

  function automatic logic [sfpi_pkg::MEM_AW-1:0] lin(
    input logic [sfpi_pkg::PAGE_W-1:0] p,
    input logic [sfpi_pkg::BYTE_W-1:0] b
  );
    lin = sfpi_pkg::MEM_AW'(p * sfpi_pkg::PAGE_BIG) + sfpi_pkg::MEM_AW'(b);
  endfunction : lin

  // edges only from the second synchroniser flop
  assign sel = ~cs_n_s;
  assign cs_fall = cs_prev_q & ~cs_n_s;
  assign cs_rise = ~cs_prev_q & cs_n_s;
  // edge detection on both polarities covers mode 0 and mode 3 idle levels
  assign sck_rise = sel & ~sck_prev_q & sck_s;
  assign sck_fall = sel & sck_prev_q & ~sck_s;
  assign byte_in = {rx_q[6:0], si_s};
  assign byte_done = sck_rise && (bitc_q == 3'd7);
  assign int_clr = (por_q != 8'h00) | ~rstp_n_s;
  assign idle = (opst_q == OPS_IDLE);
  assign psize = bin_q ? sfpi_pkg::BYTE_W'(sfpi_pkg::PAGE_BIN) : sfpi_pkg::BYTE_W'(sfpi_pkg::PAGE_BIG);
  assign tgt_sect = tgt_q[sfpi_pkg::PAGE_W-1 -: sfpi_pkg::SECT_W];
  assign main_rd = mainm[lin(pg_q, by_q)];
  assign sec_rd = (by_q[6:0] < 7'(sfpi_pkg::SEC_FACTORY)) ? (UID_SEED ^ {1'b0, by_q[6:0]})
    : (otp_used_q ? secu[by_q[5:0]] : sfpi_pkg::ERASED);
  always_comb begin
    status = 8'h00;
    status[sfpi_pkg::ST_READY] = idle;
    status[sfpi_pkg::ST_WP] = ~wp_n_s;
    status[sfpi_pkg::ST_PROT] = prot_en_q;
    status[sfpi_pkg::ST_BIN] = bin_q;
  end

  // power-on hold so the reset pin needs no sequencing
  always_comb begin
    por_d = (por_q != 8'h00) ? por_q - 8'h01 : por_q;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      por_q <= 8'(sfpi_pkg::POR_CYC);
      cs_prev_q <= 1'b1;
      sck_prev_q <= 1'b0;
    end else begin
      por_q <= por_d;
      cs_prev_q <= cs_n_s;
      sck_prev_q <= sck_s;
    end
  end

  always_comb begin
    logic blocked;
    blocked = 1'b0;
    phase_d = phase_q; opst_d = opst_q; opc_d = opc_q; rx_d = rx_q; tx_d = tx_q;
    bitc_d = bitc_q; bytec_d = bytec_q; addr_d = addr_q; pg_d = pg_q; by_d = by_q;
    tgt_d = tgt_q; idx_d = idx_q; cmd_done_d = cmd_done_q; src_d = src_q;
    so_d = so_q; tmr_d = tmr_q; prot_en_d = prot_en_q; bin_d = bin_q;
    otp_used_d = otp_used_q; mask_d = mask_q; lock_d = lock_q;
    bw_en = 1'b0; bw_sel = 1'b0; bw_idx = by_q; bw_data = byte_in;
    mw_en = 1'b0; mw_idx = lin(tgt_q, idx_q); mw_data = sfpi_pkg::ERASED;
    sw_en = 1'b0; sw_idx = idx_q[5:0]; sw_data = bufm[0][idx_q];
    // self-timed engine runs on its own, regardless of select
    if (!idle) begin
      tmr_d = tmr_q - 32'd1;
      if (opst_q == OPS_OTP) begin
        if (idx_q < sfpi_pkg::BYTE_W'(sfpi_pkg::SEC_FACTORY)) begin
          sw_en = 1'b1;
          idx_d = idx_q + 1'b1;
        end
      end else if (idx_q < psize) begin
        mw_en = 1'b1;
        mw_data = (opst_q == OPS_PROG) ? bufm[src_q][idx_q] : sfpi_pkg::ERASED;
        idx_d = idx_q + 1'b1;
      end
      if (tmr_q == 32'd1) opst_d = OPS_IDLE;
    end
    if (sck_rise) begin
      rx_d = byte_in;
      bitc_d = bitc_q + 3'd1;
    end
    if (sck_fall && phase_q == PH_RDATA) begin
      so_d = tx_q[7];
      tx_d = {tx_q[6:0], 1'b0};
    end
    if (byte_done) begin
      case (phase_q)
        PH_OPCODE: begin
          opc_d = byte_in;
          bytec_d = 2'd0;
          case (byte_in)
            sfpi_pkg::OP_STATUS: begin
              phase_d = PH_RDATA;
              tx_d = status;
            end
            sfpi_pkg::OP_PROT_ENABLE, sfpi_pkg::OP_PROT_DISABLE,
            sfpi_pkg::OP_PAGE_BIN, sfpi_pkg::OP_PAGE_BIG: begin
              phase_d = PH_DONE;
              cmd_done_d = 1'b1;
            end
            sfpi_pkg::OP_BUF1_WRITE, sfpi_pkg::OP_BUF2_WRITE, sfpi_pkg::OP_BUF1_PROG,
            sfpi_pkg::OP_BUF2_PROG, sfpi_pkg::OP_PAGE_ERASE, sfpi_pkg::OP_ARRAY_READ,
            sfpi_pkg::OP_SEC_READ, sfpi_pkg::OP_SEC_PROG, sfpi_pkg::OP_PROT_WRITE,
            sfpi_pkg::OP_LOCKDOWN: phase_d = PH_ADDR;
            default: phase_d = PH_DONE;
          endcase
        end
        PH_ADDR: begin
          addr_d = {addr_q[15:0], byte_in};
          bytec_d = bytec_q + 2'd1;
          if (bytec_q == 2'(sfpi_pkg::ADDR_BYTES - 1)) begin
            pg_d = bin_q ? addr_d[19:8] : addr_d[20:9];
            by_d = bin_q ? {1'b0, addr_d[7:0]} : addr_d[8:0];
            cmd_done_d = 1'b1;
            case (opc_q)
              sfpi_pkg::OP_BUF1_WRITE, sfpi_pkg::OP_BUF2_WRITE,
              sfpi_pkg::OP_SEC_PROG: phase_d = PH_WDATA;
              // array is not readable while it is being rewritten
              sfpi_pkg::OP_ARRAY_READ: phase_d = idle ? PH_DUMMY : PH_DONE;
              sfpi_pkg::OP_SEC_READ: begin
                phase_d = PH_RDATA;
                by_d = {2'b00, addr_d[6:0]};
                tx_d = (addr_d[6:0] < 7'(sfpi_pkg::SEC_FACTORY))
                  ? (UID_SEED ^ {1'b0, addr_d[6:0]})
                  : (otp_used_q ? secu[addr_d[5:0]] : sfpi_pkg::ERASED);
              end
              default: phase_d = PH_DONE;
            endcase
          end
        end
        PH_DUMMY: begin
          phase_d = PH_RDATA;
          tx_d = main_rd;
          by_d = by_q + 1'b1;
          if (by_q + 1'b1 == psize) begin
            by_d = '0;
            pg_d = pg_q + 1'b1; // wraps past the last page
          end
        end
        PH_RDATA: begin
          if (opc_q == sfpi_pkg::OP_STATUS) begin
            tx_d = status;
          end else if (opc_q == sfpi_pkg::OP_SEC_READ) begin
            tx_d = sec_rd;
            by_d = {2'b00, by_q[6:0] + 7'd1};
          end else begin
            tx_d = main_rd;
            by_d = by_q + 1'b1;
            if (by_q + 1'b1 == psize) begin
              by_d = '0;
              pg_d = pg_q + 1'b1;
            end
          end
        end
        PH_WDATA: begin
          bw_sel = (opc_q == sfpi_pkg::OP_BUF2_WRITE);
          // a buffer feeding the array is locked; the other stays writable
          bw_en = !(!idle && opst_q == OPS_PROG && src_q == bw_sel);
          by_d = (by_q + 1'b1 == psize) ? '0 : by_q + 1'b1;
        end
        default: ;
      endcase
    end
    if (cs_fall) begin
      phase_d = PH_OPCODE;
      bitc_d = 3'd0;
      cmd_done_d = 1'b0;
    end
    if (cs_rise) begin
      phase_d = PH_IDLE;
      if (cmd_done_q) begin
        blocked = ~wp_n_s | lock_q[pg_q[sfpi_pkg::PAGE_W-1 -: sfpi_pkg::SECT_W]]
          | (prot_en_q & mask_q[pg_q[sfpi_pkg::PAGE_W-1 -: sfpi_pkg::SECT_W]]);
        case (opc_q)
          sfpi_pkg::OP_BUF1_PROG, sfpi_pkg::OP_BUF2_PROG, sfpi_pkg::OP_PAGE_ERASE: begin
            if (idle && !blocked) begin
              opst_d = (opc_q == sfpi_pkg::OP_PAGE_ERASE) ? OPS_ERASE : OPS_PROG;
              tmr_d = (opc_q == sfpi_pkg::OP_PAGE_ERASE) ? 32'(ERASE_CYCLES) : 32'(PROG_CYCLES);
              src_d = (opc_q == sfpi_pkg::OP_BUF2_PROG);
              tgt_d = pg_q;
              idx_d = '0;
            end
          end
          sfpi_pkg::OP_SEC_PROG: begin
            if (idle && wp_n_s && !otp_used_q) begin
              opst_d = OPS_OTP;
              tmr_d = 32'(PROG_CYCLES);
              otp_used_d = 1'b1;
              idx_d = '0;
            end
          end
          sfpi_pkg::OP_PROT_ENABLE: prot_en_d = 1'b1;
          sfpi_pkg::OP_PROT_DISABLE: if (wp_n_s) prot_en_d = 1'b0;
          sfpi_pkg::OP_PROT_WRITE: if (wp_n_s && idle) mask_d = addr_q[sfpi_pkg::SECTORS-1:0];
          sfpi_pkg::OP_LOCKDOWN: lock_d[pg_q[sfpi_pkg::PAGE_W-1 -: sfpi_pkg::SECT_W]] = 1'b1;
          sfpi_pkg::OP_PAGE_BIN: bin_d = 1'b1;
          sfpi_pkg::OP_PAGE_BIG: if (!FACTORY_BIN) bin_d = 1'b0;
          default: ;
        endcase
      end
    end
    if (int_clr) begin
      phase_d = PH_IDLE;
      opst_d = OPS_IDLE;
      cmd_done_d = 1'b0;
      bw_en = 1'b0;
      mw_en = 1'b0;
      sw_en = 1'b0;
    end
    oe_d = sel && (phase_d == PH_RDATA);
    stby_d = cs_n_s && (opst_d == OPS_IDLE);
    busy_d = (opst_d != OPS_IDLE);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_q <= PH_IDLE;
      opst_q <= OPS_IDLE;
      opc_q <= 8'h00;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      bitc_q <= 3'd0;
      bytec_q <= 2'd0;
      addr_q <= 24'h000000;
      pg_q <= '0;
      by_q <= '0;
      tgt_q <= '0;
      idx_q <= '0;
      cmd_done_q <= 1'b0;
      src_q <= 1'b0;
      so_q <= 1'b0;
      oe_q <= 1'b0;
      stby_q <= 1'b1;
      busy_q <= 1'b0;
      tmr_q <= 32'h00000000;
      prot_en_q <= 1'b0;
      bin_q <= FACTORY_BIN;
      otp_used_q <= 1'b0;
      mask_q <= '0;
      lock_q <= '0;
    end else begin
      phase_q <= phase_d;
      opst_q <= opst_d;
      opc_q <= opc_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      bitc_q <= bitc_d;
      bytec_q <= bytec_d;
      addr_q <= addr_d;
      pg_q <= pg_d;
      by_q <= by_d;
      tgt_q <= tgt_d;
      idx_q <= idx_d;
      cmd_done_q <= cmd_done_d;
      src_q <= src_d;
      so_q <= so_d;
      oe_q <= oe_d;
      stby_q <= stby_d;
      busy_q <= busy_d;
      tmr_q <= tmr_d;
      prot_en_q <= prot_en_d;
      bin_q <= bin_d;
      otp_used_q <= otp_used_d;
      mask_q <= mask_d;
      lock_q <= lock_d;
    end
  end

  // storage has no reset; contents survive like the real cells
  always_ff @(posedge clk) begin
    if (bw_en) bufm[bw_sel][bw_idx] <= bw_data;
    if (mw_en) mainm[mw_idx] <= mw_data;
    if (sw_en) secu[sw_idx] <= sw_data;
  end

  assign so = so_q;
  assign so_oe = oe_q;
  assign standby = stby_q;
  assign busy = busy_q;
endmodule : sfpi_core
`default_nettype wire

// ---- verif/sfpi_checker.sv ----
// concurrent checks on the pins of the serial flash pin interface
`timescale 1ns/1ps
`default_nettype none
module sfpi_checker #(
  parameter int unsigned PROG_CYCLES = 30000,
  parameter int unsigned ERASE_CYCLES = 40000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic wp_n,
  input wire logic reset_n,
  input wire logic so,
  input wire logic so_oe,
  input wire logic standby,
  input wire logic busy
);
  logic [31:0] run_d;
  logic [31:0] run_q;
  logic abort_d;
  logic abort_q;
  // busy length counter; an abort by the reset pin excuses a short run
  always_comb begin
    run_d = busy ? run_q + 32'h1 : 32'h0;
    abort_d = busy && (abort_q || !reset_n);
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_q <= '0;
      abort_q <= 1'b0;
    end else begin
      run_q <= run_d;
      abort_q <= abort_d;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_desel;
    cs_n [*4];
  endsequence
  sequence s_sel;
    !cs_n [*4];
  endsequence
  sequence s_op_end;
    ($fell(busy) && !abort_q) ##1 cs_n [*2];
  endsequence
  a_desel_float: assert property (s_desel |-> !so_oe)
    else $error("output driven while deselected");
  a_sel_awake: assert property (s_sel |-> !standby)
    else $error("standby while selected");
  a_busy_no_stby: assert property (busy |-> !standby)
    else $error("standby during self-timed operation");
  a_op_standby: assert property (s_desel ##0 s_op_end |-> standby)
    else $error("no standby after operation end");
  a_launch_on_rise: assert property ($rose(busy) |-> cs_n && $past(cs_n))
    else $error("operation launched while selected");
  a_wp_blocks: assert property ($rose(busy) |-> wp_n)
    else $error("operation launched under write protect");
  a_so_on_fall: assert property ($past(so_oe) && so_oe && $changed(so)
    |-> !sck && !$past(sck, 2))
    else $error("output changed away from clock fall");
  a_oe_selected: assert property ($rose(so_oe) |-> !cs_n)
    else $error("output enabled without select");
  a_pin_abort: assert property (!reset_n [*4] |-> !busy && !so_oe)
    else $error("reset pin did not abort");
  a_self_timed: assert property ($fell(busy) && !abort_q |->
    (run_q + 1 >= PROG_CYCLES && run_q <= PROG_CYCLES + 1) ||
    (run_q + 1 >= ERASE_CYCLES && run_q <= ERASE_CYCLES + 1))
    else $error("self-timed length wrong");
endmodule : sfpi_checker
bind sfpi_core sfpi_checker #(
  .PROG_CYCLES(PROG_CYCLES),
  .ERASE_CYCLES(ERASE_CYCLES)
) u_checker (
  .clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n),
  .reset_n(reset_n), .so(so), .so_oe(so_oe), .standby(standby), .busy(busy)
);
`default_nettype wire

// ---- verif/sfpi_host.sv ----
// spi host model driving select, clock and data
`timescale 1ns/1ps
`default_nettype none
module sfpi_host (
  input wire logic clk,
  input wire logic so,
  output var logic cs_n,
  output var logic sck,
  output var logic si
);
  bit mode3;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  // garbage on data while deselected, so ignoring it is really tested
  always @(negedge clk) if (cs_n) si <= ~si;
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_n
  task automatic begin_frame(input bit m3);
    mode3 = m3;
    sck = m3;
    wait_n(4);
    cs_n = 1'b0;
    wait_n(4);
  endtask : begin_frame
  // half period of four clocks leaves the synchronisers room
  task automatic put_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      si = tx[i];
      wait_n(4);
      rx[i] = so;
      sck = 1'b1;
      wait_n(4);
    end
  endtask : put_byte
  task automatic end_frame();
    sck = mode3;
    wait_n(4);
    cs_n = 1'b1;
    wait_n(4);
  endtask : end_frame
endmodule : sfpi_host
`default_nettype wire

// ---- verif/sfpi_core_bench.sv ----
// self-checking bench for the serial flash pin interface
`timescale 1ns/1ps
`default_nettype none
module sfpi_core_bench;
  localparam int unsigned PCYC = 1000;
  localparam int unsigned ECYC = 1100;
  logic clk, rst, reset_n, wp_en, wp_val, cs_n, sck, si, so, so_oe, standby, busy;
  tri1 wp_n;
  integer seed;
  int n_mismatch = 0;
  int checks = 0;
  int cycles = 0;
  logic [31:0] wdat, rd, d1;
  logic [11:0] p1, p2;
  logic [8:0] b1;
  assign wp_n = wp_en ? wp_val : 1'bz;
  sfpi_core #(.PROG_CYCLES(PCYC), .ERASE_CYCLES(ECYC)) dut (
    .clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n),
    .reset_n(reset_n), .so(so), .so_oe(so_oe), .standby(standby), .busy(busy));
  sfpi_host u_host (.clk(clk), .so(so), .cs_n(cs_n), .sck(sck), .si(si));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  function automatic logic [23:0] a264(input logic [11:0] pg, input logic [8:0] by);
    return {3'b000, pg, by};
  endfunction : a264
  function automatic logic [31:0] st(input bit rdy, input bit wpl, input bit pr, input bit bn);
    return {24'h0, rdy, 4'h0, wpl, pr, bn};
  endfunction : st
  // one whole frame; mode 0 or 3 drawn at random each time
  task automatic frame(input logic [7:0] op, input logic [23:0] adr, input int na,
      input int nw, input int nr);
    logic [7:0] r;
    u_host.begin_frame(1'($random(seed)));
    u_host.put_byte(op, r);
    for (int i = na - 1; i >= 0; i--) u_host.put_byte(adr[8*i +: 8], r);
    for (int i = 0; i < nw; i++) u_host.put_byte(wdat[31-8*i -: 8], r);
    rd = '0;
    for (int i = 0; i < nr; i++) begin
      u_host.put_byte(8'h00, r);
      rd = {rd[23:0], r};
    end
    u_host.end_frame();
  endtask : frame
  task automatic stat();
    frame(sfpi_pkg::OP_STATUS, '0, 0, 0, 1);
    rd = rd & 32'h87;
  endtask : stat
  task automatic wait_idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < ECYC + 50) begin
      tick(1);
      k++;
    end
    check(32'(k < ECYC + 50), 32'h1);
    tick(2);
  endtask : wait_idle
  // refused launch: nothing starts, device sits idle
  task automatic no_launch();
    tick(10);
    check({30'h0, busy, standby}, 32'h1);
  endtask : no_launch
  initial begin
    seed = 25350;
    rst = 1'b1;
    reset_n = 1'b1;
    wp_en = 1'b0;
    wp_val = 1'b0;
    tick(3);
    check({29'h0, standby, busy, so_oe}, 32'h4);
    tick(3);
    rst = 1'b0;
    tick(25);
    stat();
    check(rd, st(1, 0, 0, 0));
    wp_en = 1'b1;
    stat();
    check(rd, st(1, 1, 0, 0));
    frame(sfpi_pkg::OP_PAGE_BIN, '0, 0, 0, 0);
    stat();
    check(rd, st(1, 1, 0, 1));
    frame(sfpi_pkg::OP_PAGE_BIG, '0, 0, 0, 0);
    stat();
    check(rd, st(1, 1, 0, 0));
    wp_en = 1'b0;
    p1 = {4'h2, 8'($random(seed))};
    p2 = {4'h3, 8'($random(seed))};
    b1 = 9'($random(seed)) % 9'd260;
    wdat = $random(seed);
    d1 = wdat;
    frame(sfpi_pkg::OP_BUF1_WRITE, a264(12'h0, b1), 3, 4, 0);
    frame(sfpi_pkg::OP_BUF1_PROG, a264(p1, 9'h0), 3, 0, 0);
    tick(2);
    check({30'h0, busy, standby}, 32'h2);
    stat();
    check(rd, st(0, 0, 0, 0));
    wdat = $random(seed);
    frame(sfpi_pkg::OP_BUF2_WRITE, a264(12'h0, b1), 3, 1, 0);
    wait_idle();
    check({31'h0, standby}, 32'h1);
    frame(sfpi_pkg::OP_BUF2_PROG, a264(p2, 9'h0), 3, 0, 0);
    wait_idle();
    frame(sfpi_pkg::OP_ARRAY_READ, a264(p1, b1), 3, 0, 5);
    check(rd, d1);
    frame(sfpi_pkg::OP_ARRAY_READ, a264(p2, b1), 3, 0, 2);
    check({24'h0, rd[7:0]}, {24'h0, wdat[31:24]});
    frame(sfpi_pkg::OP_PAGE_ERASE, a264(p1, 9'h0), 3, 0, 0);
    wait_idle();
    wp_en = 1'b1;
    frame(sfpi_pkg::OP_BUF1_PROG, a264(p1, 9'h0), 3, 0, 0);
    no_launch();
    frame(sfpi_pkg::OP_PAGE_ERASE, a264(p2, 9'h0), 3, 0, 0);
    no_launch();
    frame(sfpi_pkg::OP_ARRAY_READ, a264(p1, b1), 3, 0, 5);
    check(rd, 32'hffffffff);
    wp_en = 1'b0;
    frame(sfpi_pkg::OP_PROT_WRITE, 24'h008000, 3, 0, 0);
    wp_en = 1'b1;
    frame(sfpi_pkg::OP_PROT_WRITE, 24'h000000, 3, 0, 0);
    frame(sfpi_pkg::OP_PROT_ENABLE, '0, 0, 0, 0);
    stat();
    check(rd, st(1, 1, 1, 0));
    wp_en = 1'b0;
    frame(sfpi_pkg::OP_BUF1_PROG, a264({4'hf, p1[7:0]}, 9'h0), 3, 0, 0);
    no_launch();
    frame(sfpi_pkg::OP_PROT_DISABLE, '0, 0, 0, 0);
    stat();
    check(rd, st(1, 0, 0, 0));
    frame(sfpi_pkg::OP_BUF1_PROG, a264({4'hf, p1[7:0]}, 9'h0), 3, 0, 0);
    tick(50);
    check({31'h0, busy}, 32'h1);
    reset_n = 1'b0;
    tick(4);
    check({30'h0, busy, so_oe}, 32'h0);
    tick(10);
    reset_n = 1'b1;
    tick(6);
    stat();
    check(rd, st(1, 0, 0, 0));
    report_and_stop();
  end
endmodule : sfpi_core_bench
`default_nettype wire
